// file: ctp_timer.sv
`timescale 1ns/10ps
// Operation
// - modulation mode counts up from the selected clock, 8-bit pulse width
// - counter equal to duty inverts output flip-flop, counting continues
// - overflow inverts flip-flop again, clears counter, raises timer irq
// - flip-flop starts from initial-value bit; reset clears it to 0
// - modulated pin is always the inverse of the flip-flop
// - duty writes while running wait in holding stage until irq
// - duty writes while stopped go active at once
// - duty reads while modulating return the active stage
// - stopping keeps the pin level it had
// - run is bit 3, initial-value bit 7; clear bit 7 stopped gives pin high
// - sources include full, half and low-frequency clocks plus taps
// - interval mode cascades both counters into one 16-bit counter
// - after upper run set, 16-bit match raises upper irq and clears
// - interval compare is unbuffered and applies at once
module ctp_timer
    import ctp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        low_freq_clock,
    input  wire logic        divider_tap_select,
    output logic             modulated_output_pin_lo,
    output logic             modulated_output_pin_up,
    output logic             timer_irq_lo,
    output logic             upper_timer_irq
);
    // ==========================================================
    // bus decode
    logic acc;
    logic wr_en;
    logic w_lctrl;
    logic w_uctrl;
    logic w_dutyl;
    logic w_dutyu;
    logic w_cmpl;
    logic w_cmph;
    // one register word per offset, no aliasing
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : reg_hit
    assign acc     = psel & penable;
    assign wr_en   = acc & pwrite;
    // zero wait: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign w_lctrl = wr_en && reg_hit(paddr, CTP_OFF_LCTRL);
    assign w_uctrl = wr_en && reg_hit(paddr, CTP_OFF_UCTRL);
    assign w_dutyl = wr_en && reg_hit(paddr, CTP_OFF_DUTYL);
    assign w_dutyu = wr_en && reg_hit(paddr, CTP_OFF_DUTYU);
    assign w_cmpl  = wr_en && reg_hit(paddr, CTP_OFF_CMPL);
    assign w_cmph  = wr_en && reg_hit(paddr, CTP_OFF_CMPH);

    // ==========================================================
    // control and compare registers
    logic [7:0] lctl_ff;
    logic [7:0] nxt_lctl;
    logic [7:0] uctl_ff;
    logic [7:0] nxt_uctl;
    logic [7:0] cmpl_ff;
    logic [7:0] nxt_cmpl;
    logic [7:0] cmph_ff;
    logic [7:0] nxt_cmph;
    ctp_ctrl_t  lc;
    ctp_ctrl_t  uc;
    always_comb begin
        nxt_lctl = w_lctrl ? pwdata[7:0] : lctl_ff;
        nxt_uctl = w_uctrl ? pwdata[7:0] : uctl_ff;
        nxt_cmpl = w_cmpl  ? pwdata[7:0] : cmpl_ff;
        nxt_cmph = w_cmph  ? pwdata[7:0] : cmph_ff;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lctl_ff <= CTP_CTRL_RST;
            uctl_ff <= CTP_CTRL_RST;
            cmpl_ff <= CTP_CNT_ZERO;
            cmph_ff <= CTP_CNT_ZERO;
        end else begin
            lctl_ff <= nxt_lctl;
            uctl_ff <= nxt_uctl;
            cmpl_ff <= nxt_cmpl;
            cmph_ff <= nxt_cmph;
        end
    end
    assign lc = ctp_unpack(lctl_ff);
    assign uc = ctp_unpack(uctl_ff);

    // ==========================================================
    // mode and clock selection
    logic wide;
    logic pwm_l;
    logic pwm_u;
    logic run_l;
    logic run_u;
    logic tick_l;
    logic tick_u;
    assign wide  = uc.mode == CTP_MODE_WIDE;
    assign pwm_l = !wide && lc.mode == CTP_MODE_PWM;
    assign pwm_u = !wide && uc.mode == CTP_MODE_PWM;
    assign run_l = lc.run && !wide;
    assign run_u = uc.run;

    ctp_tick_gen u_tick_l (
        .pclk               (pclk),
        .presetn            (presetn),
        .low_freq_clock     (low_freq_clock),
        .divider_tap_select (divider_tap_select),
        .sel_valid          (run_l),
        .sel                (lc.src),
        .tick               (tick_l)
    );
    // wide mode takes its source from the lower control
    ctp_tick_gen u_tick_u (
        .pclk               (pclk),
        .presetn            (presetn),
        .low_freq_clock     (low_freq_clock),
        .divider_tap_select (divider_tap_select),
        .sel_valid          (run_u),
        .sel                (wide ? lc.src : uc.src),
        .tick               (tick_u)
    );

    // ==========================================================
    // duty buffers
    logic [7:0] hold_l;
    logic [7:0] act_l;
    logic [7:0] hold_u;
    logic [7:0] act_u;
    logic       irq_l;
    logic       irq_u;
    ctp_duty_buf u_duty_l (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr        (w_dutyl),
        .wdata     (pwdata[7:0]),
        .running   (run_l),
        .irq_pulse (irq_l),
        .hold_q    (hold_l),
        .active_q  (act_l)
    );
    ctp_duty_buf u_duty_u (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr        (w_dutyu),
        .wdata     (pwdata[7:0]),
        .running   (run_u),
        .irq_pulse (irq_u),
        .hold_q    (hold_u),
        .active_q  (act_u)
    );

    // ==========================================================
    // counters and output flip-flops
    logic [7:0]  cnt_l_ff;
    logic [7:0]  nxt_cnt_l;
    logic [7:0]  cnt_u_ff;
    logic [7:0]  nxt_cnt_u;
    logic        tff_l_ff;
    logic        nxt_tff_l;
    logic        tff_u_ff;
    logic        nxt_tff_u;
    logic        irq_l_ff;
    logic        nxt_irq_l;
    logic        irq_u_ff;
    logic        nxt_irq_u;
    logic [15:0] wcnt;
    logic [15:0] wcmp;
    assign wcnt = {cnt_u_ff, cnt_l_ff};
    assign wcmp = {cmph_ff, cmpl_ff};

    always_comb begin
        nxt_cnt_l = cnt_l_ff;
        nxt_cnt_u = cnt_u_ff;
        nxt_tff_l = tff_l_ff;
        nxt_tff_u = tff_u_ff;
        nxt_irq_l = 1'b0;
        nxt_irq_u = 1'b0;
        // lower counter
        if (!run_l) begin
            // a stopping write leaves the flip-flop, so the pin holds its level
            if (!wide) begin
                nxt_cnt_l = CTP_CNT_ZERO;
                if (w_lctrl) begin
                    nxt_tff_l = pwdata[CTP_TFF_BIT];
                end
            end
        end else if (tick_l) begin
            nxt_cnt_l = cnt_l_ff + 1'b1;
            if (pwm_l && cnt_l_ff == CTP_CNT_MAX) begin
                nxt_tff_l = ~tff_l_ff;
                nxt_cnt_l = CTP_CNT_ZERO;
                nxt_irq_l = 1'b1;
            end else if (pwm_l && cnt_l_ff == act_l) begin
                nxt_tff_l = ~tff_l_ff;
            end else if (!pwm_l && cnt_l_ff + 1'b1 == cmpl_ff) begin
                nxt_cnt_l = CTP_CNT_ZERO;
                nxt_irq_l = 1'b1;
            end
        end
        // upper counter, or the 16-bit pair
        if (!run_u) begin
            nxt_cnt_u = CTP_CNT_ZERO;
            if (w_uctrl) begin
                nxt_tff_u = pwdata[CTP_TFF_BIT];
            end
            if (wide) begin
                nxt_cnt_l = CTP_CNT_ZERO;
            end
        end else if (tick_u) begin
            if (wide) begin
                if (16'(wcnt + 1'b1) == wcmp) begin
                    {nxt_cnt_u, nxt_cnt_l} = CTP_W_ZERO;
                    nxt_irq_u = 1'b1;
                end else begin
                    {nxt_cnt_u, nxt_cnt_l} = 16'(wcnt + 1'b1);
                end
            end else begin
                nxt_cnt_u = cnt_u_ff + 1'b1;
                if (pwm_u && cnt_u_ff == CTP_CNT_MAX) begin
                    nxt_tff_u = ~tff_u_ff;
                    nxt_cnt_u = CTP_CNT_ZERO;
                    nxt_irq_u = 1'b1;
                end else if (pwm_u && cnt_u_ff == act_u) begin
                    nxt_tff_u = ~tff_u_ff;
                end else if (!pwm_u && cnt_u_ff + 1'b1 == cmph_ff) begin
                    nxt_cnt_u = CTP_CNT_ZERO;
                    nxt_irq_u = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_l_ff <= CTP_CNT_ZERO;
            cnt_u_ff <= CTP_CNT_ZERO;
            tff_l_ff <= 1'b0;
            tff_u_ff <= 1'b0;
            irq_l_ff <= 1'b0;
            irq_u_ff <= 1'b0;
        end else begin
            cnt_l_ff <= nxt_cnt_l;
            cnt_u_ff <= nxt_cnt_u;
            tff_l_ff <= nxt_tff_l;
            tff_u_ff <= nxt_tff_u;
            irq_l_ff <= nxt_irq_l;
            irq_u_ff <= nxt_irq_u;
        end
    end
    assign irq_l = nxt_irq_l;
    assign irq_u = nxt_irq_u;
    assign timer_irq_lo            = irq_l_ff;
    assign upper_timer_irq         = irq_u_ff;
    assign modulated_output_pin_lo = ~tff_l_ff;
    assign modulated_output_pin_up = ~tff_u_ff;

    // ==========================================================
    // read mux
    logic [31:0] rd_ff;
    logic [31:0] nxt_rd;
    // modulating: software sees the duty in use until the reload
    function automatic logic [7:0] duty_view(input logic pwm, input logic [7:0] hold,
                                             input logic [7:0] act);
        return pwm ? act : hold;
    endfunction : duty_view
    // read data is latched in setup so it stands through the access cycle
    always_comb begin
        nxt_rd = rd_ff;
        if (psel && !penable && !pwrite) begin
            if (paddr == CTP_OFF_LCTRL) nxt_rd = {24'h0, lctl_ff};
            else if (paddr == CTP_OFF_UCTRL) nxt_rd = {24'h0, uctl_ff};
            else if (paddr == CTP_OFF_DUTYL) begin
                nxt_rd = {24'h0, duty_view(pwm_l, hold_l, act_l)};
            end else if (paddr == CTP_OFF_DUTYU) begin
                nxt_rd = {24'h0, duty_view(pwm_u, hold_u, act_u)};
            end else if (paddr == CTP_OFF_CMPL) nxt_rd = {24'h0, cmpl_ff};
            else if (paddr == CTP_OFF_CMPH) nxt_rd = {24'h0, cmph_ff};
            else if (paddr == CTP_OFF_STAT) nxt_rd = {28'h0, tff_u_ff, tff_l_ff, run_u, run_l};
            else if (paddr == CTP_OFF_CNT) nxt_rd = {16'h0, wcnt};
            else nxt_rd = CTP_RD_ZERO;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= CTP_RD_ZERO;
        end else begin
            rd_ff <= nxt_rd;
        end
    end
    assign prdata  = rd_ff;
    assign pslverr = 1'b0;
endmodule : ctp_timer

// file: ctp_pkg.sv
package ctp_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] CTP_OFF_LCTRL = 8'h00;
    localparam logic [7:0] CTP_OFF_UCTRL = 8'h04;
    localparam logic [7:0] CTP_OFF_DUTYL = 8'h08;
    localparam logic [7:0] CTP_OFF_DUTYU = 8'h0C;
    localparam logic [7:0] CTP_OFF_CMPL  = 8'h10;
    localparam logic [7:0] CTP_OFF_CMPH  = 8'h14;
    localparam logic [7:0] CTP_OFF_STAT  = 8'h18;
    localparam logic [7:0] CTP_OFF_CNT   = 8'h1C;
    // ==========================================================
    // control field layout
    localparam int CTP_RUN_BIT   = 3;
    localparam int CTP_TFF_BIT   = 7;
    localparam int CTP_MODE_LSB  = 0;
    localparam int CTP_CK_LSB    = 4;
    localparam logic [2:0] CTP_MODE_TIMER = 3'h0;
    localparam logic [2:0] CTP_MODE_PWM   = 3'h3;
    localparam logic [2:0] CTP_MODE_WIDE  = 3'h4;
    localparam logic [7:0] CTP_CTRL_RST   = 8'h00;
    localparam logic [7:0] CTP_CNT_MAX    = 8'hFF;
    localparam logic [7:0] CTP_CNT_ZERO   = 8'h00;
    localparam logic [15:0] CTP_W_ZERO    = 16'h0000;
    localparam logic [31:0] CTP_RD_ZERO   = 32'h0000_0000;
    // ==========================================================
    // source clock selections
    typedef enum logic [2:0] {
        CTP_SRC_DIV11 = 3'h0,
        CTP_SRC_DIV7  = 3'h1,
        CTP_SRC_DIV5  = 3'h2,
        CTP_SRC_DIV3  = 3'h3,
        CTP_SRC_LOWF  = 3'h4,
        CTP_SRC_HALF  = 3'h5,
        CTP_SRC_FULL  = 3'h6,
        CTP_SRC_NONE  = 3'h7
    } ctp_src_t;
    localparam int CTP_DIV_W = 11;
    typedef struct packed {
        logic       run;
        logic       tff;
        logic [2:0] mode;
        ctp_src_t   src;
    } ctp_ctrl_t;
    function automatic ctp_ctrl_t ctp_unpack(input logic [7:0] r);
        ctp_ctrl_t c;
        c.run  = r[CTP_RUN_BIT];
        c.tff  = r[CTP_TFF_BIT];
        c.mode = r[CTP_MODE_LSB +: 3];
        c.src  = ctp_src_t'(r[CTP_CK_LSB +: 3]);
        return c;
    endfunction : ctp_unpack
endpackage : ctp_pkg

// file: ctp_tick_gen.sv
`timescale 1ns/10ps
module ctp_tick_gen
    import ctp_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   low_freq_clock,
    input  wire logic   divider_tap_select,
    input  wire logic   sel_valid,
    input  ctp_src_t    sel,
    output logic        tick
);
    // ==========================================================
    // prescaler: high_freq_clock is pclk
    logic [CTP_DIV_W-1:0] div_ff, nxt_div;
    logic [2:0]           lf_ff, nxt_lf;
    logic [3:0]           lfd_ff, nxt_lfd;
    logic                 lf_edge;
    logic                 half_ff, nxt_half;
    always_comb begin
        nxt_div  = div_ff + 1'b1;
        nxt_lf   = {lf_ff[1:0], low_freq_clock};
        lf_edge  = lf_ff[1] & ~lf_ff[2];
        nxt_lfd  = lf_edge ? lfd_ff + 1'b1 : lfd_ff;
        nxt_half = ~half_ff;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff  <= '0;
            lf_ff   <= '0;
            lfd_ff  <= '0;
            half_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            lf_ff   <= nxt_lf;
            lfd_ff  <= nxt_lfd;
            half_ff <= nxt_half;
        end
    end
    function automatic logic tap(input int n);
        logic [CTP_DIV_W-1:0] m;
        m = CTP_DIV_W'((32'h1 << n) - 32'h1);
        return (div_ff & m) == m;
    endfunction : tap
    always_comb begin
        tick = 1'b0;
        if (sel_valid) begin
            case (sel)
                CTP_SRC_DIV11: tick = divider_tap_select ? (lf_edge && lfd_ff[2:0] == '1)
                                                         : (div_ff == '1);
                CTP_SRC_DIV7:  tick = tap(7);
                CTP_SRC_DIV5:  tick = tap(5);
                CTP_SRC_DIV3:  tick = tap(3);
                CTP_SRC_LOWF:  tick = lf_edge;
                CTP_SRC_HALF:  tick = half_ff;
                CTP_SRC_FULL:  tick = 1'b1;
                default:       tick = 1'b0;
            endcase
        end
    end
endmodule : ctp_tick_gen

// file: ctp_duty_buf.sv
`timescale 1ns/10ps
module ctp_duty_buf
    import ctp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    input  wire logic       running,
    input  wire logic       irq_pulse,
    output logic [7:0]      hold_q,
    output logic [7:0]      active_q
);
    // ==========================================================
    // two-stage duty storage
    logic [7:0] hold_ff, nxt_hold, act_ff, nxt_act;
    always_comb begin
        nxt_hold = wr ? wdata : hold_ff;
        nxt_act  = act_ff;
        if (!running && wr) nxt_act = wdata;
        else if (running && irq_pulse) nxt_act = hold_ff;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= CTP_CNT_ZERO;
            act_ff  <= CTP_CNT_ZERO;
        end else begin
            hold_ff <= nxt_hold;
            act_ff  <= nxt_act;
        end
    end
    assign hold_q   = hold_ff;
    assign active_q = act_ff;
endmodule : ctp_duty_buf

// file: ctp_monitor.sv
`timescale 1ns/10ps
module ctp_monitor
    import ctp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        low_freq_clock,
    input wire logic        divider_tap_select,
    input wire logic        modulated_output_pin_lo,
    input wire logic        modulated_output_pin_up,
    input wire logic        timer_irq_lo,
    input wire logic        upper_timer_irq
);
    // ==========================================================
    // shadow of programmed state
    typedef struct packed {
        logic [7:0]  lc;
        logic [7:0]  uc;
        logic [15:0] cmp;
        logic [15:0] lg;
        logic [15:0] ug;
        logic [2:0]  qt;
        logic        ls;
        logic        us;
    } ctp_shadow_t;
    ctp_shadow_t sh_ff;
    ctp_shadow_t nxt_sh;
    logic        wr;
    logic        lrun;
    logic        lpwm;
    logic        wide;
    assign wr   = psel && penable && pwrite;
    assign lrun = sh_ff.lc[CTP_RUN_BIT];
    assign lpwm = sh_ff.lc[2:0] == CTP_MODE_PWM && sh_ff.lc[6:4] == CTP_SRC_FULL;
    assign wide = sh_ff.uc[2:0] == CTP_MODE_WIDE && sh_ff.lc[6:4] == CTP_SRC_FULL;
    always_comb begin
        nxt_sh    = sh_ff;
        nxt_sh.lg = timer_irq_lo ? CTP_W_ZERO : sh_ff.lg + 16'h0001;
        nxt_sh.ug = upper_timer_irq ? CTP_W_ZERO : sh_ff.ug + 16'h0001;
        nxt_sh.ls = sh_ff.ls || timer_irq_lo;
        nxt_sh.us = sh_ff.us || upper_timer_irq;
        nxt_sh.qt = (sh_ff.qt == 3'h7) ? sh_ff.qt : sh_ff.qt + 3'h1;
        if (wr && paddr == CTP_OFF_LCTRL) begin
            nxt_sh.lc = pwdata[7:0];
            nxt_sh.qt = 3'h0;
            nxt_sh.ls = 1'b0;
            nxt_sh.us = 1'b0;
        end
        if (wr && paddr == CTP_OFF_UCTRL) begin
            nxt_sh.uc = pwdata[7:0];
            nxt_sh.us = 1'b0;
        end
        if (wr && paddr == CTP_OFF_CMPL) begin
            nxt_sh.cmp[7:0] = pwdata[7:0];
            nxt_sh.us       = 1'b0;
        end
        if (wr && paddr == CTP_OFF_CMPH) begin
            nxt_sh.cmp[15:8] = pwdata[7:0];
            nxt_sh.us        = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff <= 69'h0;
        end else begin
            sh_ff <= nxt_sh;
        end
    end
    // ==========================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence stop_wr_s(bit lvl);
        wr && paddr == CTP_OFF_LCTRL && pwdata[CTP_TFF_BIT] == lvl && !pwdata[CTP_RUN_BIT] && !lrun;
    endsequence
    irq_pulse_a: assert property (timer_irq_lo |=> !timer_irq_lo)
        else $error("irq wider than one cycle");
    irq_run_a: assert property (timer_irq_lo |-> lrun || $past(lrun, 2))
        else $error("irq while stopped");
    pwm_period_a: assert property (timer_irq_lo && sh_ff.ls && lpwm |-> sh_ff.lg == 16'h00FF)
        else $error("pwm period wrong");
    wide_period_a: assert property (upper_timer_irq && sh_ff.us && wide |-> sh_ff.ug == sh_ff.cmp - 16'h0001)
        else $error("interval period wrong");
    stop_hold_a: assert property (!lrun && sh_ff.qt == 3'h7 |-> $stable(modulated_output_pin_lo))
        else $error("pin moved while stopped");
    tff_clear_a: assert property (stop_wr_s(1'b0) |-> ##3 modulated_output_pin_lo)
        else $error("pin not high");
    tff_set_a: assert property (stop_wr_s(1'b1) |-> ##3 !modulated_output_pin_lo)
        else $error("pin not low");
    unmapped_rd_a: assert property (psel && !penable && !pwrite && paddr > CTP_OFF_CNT
        |=> prdata == CTP_RD_ZERO)
        else $error("unmapped read not zero");
endmodule : ctp_monitor
bind ctp_timer ctp_monitor i_ctp_monitor (.*);

// file: cascadable_timer_pwm_and_wide_timer_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, s); end end
module cascadable_timer_pwm_and_wide_timer_tb
    import ctp_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        low_freq_clock = 1'b0;
    logic        divider_tap_select = 1'b0;
    logic [1:0]  pin;
    logic [1:0]  irq;
    logic [31:0] rd;
    int          fail_count = 0;
    int          num_checks = 0;
    // ==========================================================
    // clocks and design
    always #25 pclk = ~pclk;
    always #200 low_freq_clock = ~low_freq_clock;
    ctp_timer i_ctp_timer (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .prdata                  (prdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .low_freq_clock          (low_freq_clock),
        .divider_tap_select      (divider_tap_select),
        .modulated_output_pin_lo (pin[0]),
        .modulated_output_pin_up (pin[1]),
        .timer_irq_lo            (irq[0]),
        .upper_timer_irq         (irq[1])
    );
    // ==========================================================
    // tasks
    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // one transfer plus an idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fail_count++;
            report_and_stop();
        end
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // cycles to next irq and pin-low cycles on the way
    task automatic wait_irq(input int i, input int lim, output int c, output int l);
        c = 0;
        l = 0;
        do begin
            @(posedge pclk);
            c++;
            if (pin[i] === 1'b0) l++;
        end while (irq[i] !== 1'b1 && c < lim);
        if (c >= lim) begin
            fail_count++;
            report_and_stop();
        end
    endtask : wait_irq
    // ==========================================================
    // main sequence
    initial begin
        ctp_src_t    srcs [5];
        int          mult [5];
        int          c;
        int          l;
        logic [7:0]  d;
        logic [7:0]  d2;
        logic [7:0]  ca;
        logic [7:0]  da;
        logic [15:0] n;
        srcs = '{CTP_SRC_FULL, CTP_SRC_HALF, CTP_SRC_LOWF, CTP_SRC_DIV3, CTP_SRC_DIV11};
        mult = '{1, 2, 8, 8, 64};
        void'($urandom(32'h9837));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("reset pins", 2'b11, pin)
        apb(1'b0, CTP_OFF_UCTRL, 8'h00);
        `CHK("ctrl reset", CTP_RD_ZERO, rd)
        apb(1'b0, 8'hFC, 8'h00);
        `CHK("unmapped", CTP_RD_ZERO, rd)
        `CHK("no error", 1'b0, pslverr)
        for (int i = 0; i < 2; i++) begin
            ca = 8'(4 * i);
            da = CTP_OFF_DUTYL + ca;
            d  = (i == 0) ? 8'h02 : 8'($urandom_range(254, 2));
            apb(1'b1, ca, 8'hE3);
            repeat (3) @(posedge pclk);
            `CHK("pin init set", 1'b0, pin[i])
            apb(1'b1, ca, 8'h63);
            repeat (3) @(posedge pclk);
            `CHK("pin init clear", 1'b1, pin[i])
            apb(1'b1, da, d);
            apb(1'b0, da, 8'h00);
            `CHK("duty stopped", {24'h0, d}, rd)
            apb(1'b1, ca, 8'h6B);
            wait_irq(i, 600, c, l);
            wait_irq(i, 600, c, l);
            `CHK("pwm period", 256, c)
            `CHK("low time", 255 - int'(d), l)
            d2 = 8'($urandom_range(200, 2));
            apb(1'b1, da, d2);
            apb(1'b0, da, 8'h00);
            `CHK("duty before irq", {24'h0, d}, rd)
            wait_irq(i, 600, c, l);
            wait_irq(i, 600, c, l);
            `CHK("low after reload", 255 - int'(d2), l)
            apb(1'b0, da, 8'h00);
            `CHK("duty after irq", {24'h0, d2}, rd)
            repeat (int'(d2) + 4) @(posedge pclk);
            apb(1'b1, ca, 8'h63);
            repeat (4) @(posedge pclk);
            `CHK("pin after stop", 1'b0, pin[i])
            apb(1'b0, CTP_OFF_STAT, 8'h00);
            `CHK("status flip-flop", 1'b1, rd[2+i])
            apb(1'b1, ca, 8'h63);
            repeat (3) @(posedge pclk);
            `CHK("pin high", 1'b1, pin[i])
        end
        divider_tap_select <= 1'b1;
        apb(1'b1, CTP_OFF_DUTYL, 8'h80);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, CTP_OFF_LCTRL, {1'b0, srcs[k], 4'hB});
            wait_irq(0, 20000, c, l);
            wait_irq(0, 20000, c, l);
            `CHK("source period", 256 * mult[k], c)
        end
        apb(1'b1, CTP_OFF_LCTRL, 8'h60);
        n = 16'($urandom_range(16'h01A0, 16'h0140));
        apb(1'b1, CTP_OFF_CMPL, n[7:0]);
        apb(1'b1, CTP_OFF_CMPH, n[15:8]);
        apb(1'b1, CTP_OFF_UCTRL, 8'h04);
        apb(1'b1, CTP_OFF_UCTRL, 8'h0C);
        wait_irq(1, 2000, c, l);
        wait_irq(1, 2000, c, l);
        `CHK("interval period", int'(n), c)
        n = n + 16'h0020;
        apb(1'b1, CTP_OFF_CMPL, n[7:0]);
        apb(1'b1, CTP_OFF_CMPH, n[15:8]);
        wait_irq(1, 2000, c, l);
        `CHK("new compare", int'(n), c + 6)
        apb(1'b1, CTP_OFF_UCTRL, 8'h04);
        report_and_stop();
    end
endmodule : cascadable_timer_pwm_and_wide_timer_tb
